/* core/ast_pkg.sv */
// constants, field layout and state types of the asynchronous serial transceiver
// assumes a single 10 MHz bus clock; source clocks arrive as synchronous levels
package ast_pkg;
	// register byte offsets on the bus
	localparam logic [7:0] OFF_FORMAT = 8'h00;
	localparam logic [7:0] OFF_LINE_CTRL = 8'h04;
	localparam logic [7:0] OFF_TX_HOLD = 8'h08;
	localparam logic [7:0] OFF_TX_STATUS = 8'h0c;
	localparam logic [7:0] OFF_RX_HOLD = 8'h10;
	localparam logic [7:0] OFF_RX_STATUS = 8'h14;
	// serial_format_config fields
	localparam int FMT_XTAL_BIT = 7;
	localparam int FMT_PRESC_LSB = 3;
	localparam int FMT_ODD_BIT = 2;
	localparam int FMT_PAR_EN_BIT = 1;
	localparam int FMT_WL8_BIT = 0;
	localparam logic [7:0] FMT_RESET = 8'h01;
	localparam logic [7:0] FMT_WMASK = 8'hbf;
	// line_control fields
	localparam int CTL_ECHO_BIT = 7;
	localparam int CTL_RX_EN_BIT = 6;
	localparam int CTL_TX_EN_BIT = 5;
	localparam int CTL_RX_INV_BIT = 4;
	localparam int CTL_TX_INV_BIT = 3;
	localparam int CTL_BAUD_LSB = 0;
	localparam logic [7:0] CTL_RESET = 8'h05;
	// status fields
	localparam int TXS_FULL_BIT = 0;
	localparam int TXS_ACTIVE_BIT = 1;
	localparam int RXS_FULL_BIT = 0;
	localparam int RXS_ACTIVE_BIT = 1;
	localparam int RXS_OVERRUN_BIT = 2;
	localparam int RXS_FRAME_BIT = 3;
	localparam int RXS_PARITY_BIT = 4;
	localparam int RXS_START_BIT = 5;
	localparam logic [7:0] HOLD_RESET = 8'h00;
	// baud generation
	localparam logic [4:0] RC_TOP_EXP = 5'h07;
	localparam logic [4:0] EXT_TOP_EXP = 5'h08;
	localparam logic [4:0] MAX_EXP = 5'h0f;
	localparam logic [6:0] SAMPLES_PER_BIT = 7'h10;
	localparam logic [6:0] XTAL_BIT_CYCLES = 7'h0e;
	localparam logic [2:0] XTAL_TOP_CODE = 3'h3;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

	typedef enum logic {AST_TX_IDLE, AST_TX_SHIFT} ast_tx_e;
	typedef enum logic [1:0] {AST_RX_IDLE, AST_RX_START, AST_RX_DATA, AST_RX_STOP} ast_rx_e;

	typedef struct packed {
		logic pend;
		logic pwrite;
		logic [7:0] paddr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic [7:0] fmt;
		logic [7:0] ctrl;
		logic [2:0] src_q;
		logic rx_pin;
		logic pin_tx;
		logic [1:0] irq;
		ast_tx_e tx_state;
		logic [7:0] tx_hold;
		logic tx_full;
		logic [9:0] tx_shift;
		logic [3:0] tx_bits;
		logic [6:0] tx_cnt;
		logic tx_line;
		ast_rx_e rx_state;
		logic [6:0] rx_cnt;
		logic [3:0] rx_bits;
		logic [8:0] rx_shift;
		logic rx_start_bad;
		logic [7:0] rx_hold;
		logic rx_full;
		logic rx_serr;
		logic rx_perr;
		logic rx_ferr;
		logic rx_oerr;
	} ast_state_s;

	typedef struct packed {
		logic prev;
		logic [14:0] cnt;
		logic tick;
	} ast_tick_s;
endpackage : ast_pkg

/* core/ast_tick_gen.sv */
// sample tick generator: one pulse per 2**div_exp rising edges of a source level
// assumes src_level is already a registered, synchronous copy of the source clock
`timescale 1ns/1ns
module ast_tick_gen
	import ast_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic src_level,
	input wire logic [3:0] div_exp,
	output logic tick
);
	ast_tick_s s_reg;
	ast_tick_s s_next;
	logic [14:0] top;

	always_comb begin
		s_next = s_reg;
		top = 15'((16'h0001 << div_exp) - 16'h0001);
		s_next.prev = src_level;
		s_next.tick = 1'b0;
		if (src_level && !s_reg.prev) begin
			if (s_reg.cnt >= top) begin
				s_next.cnt = 15'h0000;
				s_next.tick = 1'b1;
			end else begin
				s_next.cnt = s_reg.cnt + 15'h0001;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '0;
		end else begin
			s_reg <= s_next;
		end
	end

	assign tick = s_reg.tick;
endmodule : ast_tick_gen

/* core/ast_transceiver.sv */
// asynchronous serial transceiver with AHB-Lite register slave
// assumes rc, external and crystal clocks arrive as levels synchronous to hclk
// Function
// - receive on port b bit7, transmit bit6
// - format bit7 picks rc/external or crystal
// - format bit2 selects odd or even parity
// - format bit1 adds and checks parity
// - format bit0 picks eight or seven bits
// - control bit7 echoes receive line to transmit
// - transmit data write sets holding full
// - load into shifter clears holding full
// - receive status write clears overrun flag
// - receive data read clears holding full
// - transmit irq line1, receive irq line0
// - outside bit chooses rc or external clock
// - rc path divides sixteen at code seven
// - prescaler extends division to 262144, 524288
// - external clock path divides extra two
// - crystal rate set by baud field only
// - crystal rates carry minus 2.48 percent error
// - separate enables for receive and transmit
// - echo and pad inversion xor the lines
// - load after frame, irq, busy flag
// - receive busy, transfer, overrun, error flags
`timescale 1ns/1ns
module ast_transceiver
	import ast_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic rc_clock_in,
	input wire logic external_clock_in,
	input wire logic crystal_clock_in,
	input wire logic external_clock_select,
	input wire logic port_b_bit7,
	output logic port_b_bit6,
	output logic [1:0] high_priority_irq_line
);
	ast_state_s s_reg;
	ast_state_s s_next;
	logic tick;
	logic [3:0] div_exp;
	logic [4:0] exp_sum;
	logic [6:0] bit_len;
	logic [2:0] baud;
	logic [2:0] presc;
	logic rx_in;
	logic [3:0] tx_len;
	logic [3:0] rx_len;
	logic tx_par;
	logic [9:0] tx_frame;
	logic [8:0] rx_aligned;
	logic [7:0] rx_word;
	logic rx_par_bit;
	logic [31:0] rdata;

	assign baud = s_reg.ctrl[CTL_BAUD_LSB +: 3];
	assign presc = s_reg.fmt[FMT_PRESC_LSB +: 3];

	// sample tick rate and bit length for the selected source
	always_comb begin
		exp_sum = 5'h00;
		bit_len = SAMPLES_PER_BIT;
		if (s_reg.fmt[FMT_XTAL_BIT]) begin
			// crystal too slow for oversampling: one sample per crystal cycle
			exp_sum = 5'h00;
			if (baud <= XTAL_TOP_CODE) begin
				bit_len = 7'(XTAL_BIT_CYCLES << (XTAL_TOP_CODE - baud));
			end else begin
				bit_len = XTAL_BIT_CYCLES;
			end
		end else if (external_clock_select) begin
			exp_sum = EXT_TOP_EXP - {2'b00, baud} + {2'b00, presc};
		end else begin
			exp_sum = RC_TOP_EXP - {2'b00, baud} + {2'b00, presc};
		end
		if (exp_sum > MAX_EXP) begin
			div_exp = MAX_EXP[3:0];
		end else begin
			div_exp = exp_sum[3:0];
		end
	end

	ast_tick_gen u_tick (
		.hclk(hclk),
		.hresetn(hresetn),
		.src_level(s_reg.fmt[FMT_XTAL_BIT] ? s_reg.src_q[2] : (external_clock_select ? s_reg.src_q[1] : s_reg.src_q[0])),
		.div_exp(div_exp),
		.tick(tick)
	);

	// frame shape from the format register
	always_comb begin
		rx_in = s_reg.rx_pin ^ s_reg.ctrl[CTL_RX_INV_BIT];
		rx_len = (s_reg.fmt[FMT_WL8_BIT] ? 4'h8 : 4'h7) + {3'b000, s_reg.fmt[FMT_PAR_EN_BIT]};
		tx_len = rx_len + 4'h1;
		if (s_reg.fmt[FMT_WL8_BIT]) begin
			tx_par = (^s_reg.tx_hold) ^ s_reg.fmt[FMT_ODD_BIT];
		end else begin
			tx_par = (^s_reg.tx_hold[6:0]) ^ s_reg.fmt[FMT_ODD_BIT];
		end
		tx_frame = 10'h3ff;
		if (s_reg.fmt[FMT_WL8_BIT]) begin
			tx_frame[7:0] = s_reg.tx_hold;
			if (s_reg.fmt[FMT_PAR_EN_BIT]) begin
				tx_frame[8] = tx_par;
			end
		end else begin
			tx_frame[6:0] = s_reg.tx_hold[6:0];
			if (s_reg.fmt[FMT_PAR_EN_BIT]) begin
				tx_frame[7] = tx_par;
			end
		end
		rx_aligned = s_reg.rx_shift >> (4'h9 - rx_len);
		if (s_reg.fmt[FMT_WL8_BIT]) begin
			rx_word = rx_aligned[7:0];
			rx_par_bit = (^rx_aligned[7:0]) ^ s_reg.fmt[FMT_ODD_BIT] ^ rx_aligned[8];
		end else begin
			rx_word = {1'b0, rx_aligned[6:0]};
			rx_par_bit = (^rx_aligned[6:0]) ^ s_reg.fmt[FMT_ODD_BIT] ^ rx_aligned[7];
		end
	end

	// register read mux
	always_comb begin
		rdata = 32'h0000_0000;
		if (s_reg.paddr == OFF_FORMAT) begin
			rdata[7:0] = s_reg.fmt;
		end else if (s_reg.paddr == OFF_LINE_CTRL) begin
			rdata[7:0] = s_reg.ctrl;
		end else if (s_reg.paddr == OFF_TX_HOLD) begin
			rdata[7:0] = s_reg.tx_hold;
		end else if (s_reg.paddr == OFF_TX_STATUS) begin
			rdata[TXS_FULL_BIT] = s_reg.tx_full;
			rdata[TXS_ACTIVE_BIT] = (s_reg.tx_state == AST_TX_SHIFT);
		end else if (s_reg.paddr == OFF_RX_HOLD) begin
			rdata[7:0] = s_reg.rx_hold;
		end else if (s_reg.paddr == OFF_RX_STATUS) begin
			rdata[RXS_FULL_BIT] = s_reg.rx_full;
			rdata[RXS_ACTIVE_BIT] = (s_reg.rx_state != AST_RX_IDLE);
			rdata[RXS_OVERRUN_BIT] = s_reg.rx_oerr;
			rdata[RXS_FRAME_BIT] = s_reg.rx_ferr;
			rdata[RXS_PARITY_BIT] = s_reg.rx_perr;
			rdata[RXS_START_BIT] = s_reg.rx_serr;
		end
	end

	always_comb begin
		s_next = s_reg;
		s_next.irq = 2'b00;
		s_next.src_q = {crystal_clock_in, external_clock_in, rc_clock_in};
		s_next.rx_pin = port_b_bit7;

		// transmitter
		case (s_reg.tx_state)
			AST_TX_IDLE: begin
				s_next.tx_line = 1'b1;
				if (s_reg.ctrl[CTL_TX_EN_BIT] && s_reg.tx_full) begin
					s_next.tx_state = AST_TX_SHIFT;
					s_next.tx_shift = tx_frame;
					s_next.tx_bits = tx_len;
					s_next.tx_cnt = 7'h00;
					s_next.tx_line = 1'b0;
					s_next.tx_full = 1'b0;
					s_next.irq[1] = 1'b1;
				end
			end
			AST_TX_SHIFT: begin
				if (tick) begin
					if (s_reg.tx_cnt >= bit_len - 7'h01) begin
						s_next.tx_cnt = 7'h00;
						if (s_reg.tx_bits == 4'h0) begin
							s_next.tx_state = AST_TX_IDLE;
							s_next.tx_line = 1'b1;
						end else begin
							s_next.tx_line = s_reg.tx_shift[0];
							s_next.tx_shift = {1'b1, s_reg.tx_shift[9:1]};
							s_next.tx_bits = s_reg.tx_bits - 4'h1;
						end
					end else begin
						s_next.tx_cnt = s_reg.tx_cnt + 7'h01;
					end
				end
			end
			default: begin
				s_next.tx_state = AST_TX_IDLE;
			end
		endcase

		// bus slave: one wait state so read data come from a flip-flop
		if (s_reg.pend) begin
			s_next.pend = 1'b0;
			s_next.hreadyout = 1'b1;
			if (s_reg.pwrite) begin
				if (s_reg.paddr == OFF_FORMAT) begin
					s_next.fmt = hwdata[7:0] & FMT_WMASK;
				end else if (s_reg.paddr == OFF_LINE_CTRL) begin
					s_next.ctrl = hwdata[7:0];
				end else if (s_reg.paddr == OFF_TX_HOLD) begin
					s_next.tx_hold = hwdata[7:0];
					s_next.tx_full = 1'b1;
				end else if (s_reg.paddr == OFF_RX_STATUS) begin
					s_next.rx_oerr = 1'b0;
				end
			end else begin
				s_next.hrdata = rdata;
				if (s_reg.paddr == OFF_RX_HOLD) begin
					s_next.rx_full = 1'b0;
				end
			end
		end else if (hsel && hready && htrans[1] && s_reg.hreadyout) begin
			s_next.pend = 1'b1;
			s_next.hreadyout = 1'b0;
			s_next.pwrite = hwrite;
			s_next.paddr = haddr[7:0];
		end

		// receiver; its flag sets come after the bus so a set beats a clear
		if (tick) begin
			case (s_reg.rx_state)
				AST_RX_IDLE: begin
					if (s_reg.ctrl[CTL_RX_EN_BIT] && !rx_in) begin
						s_next.rx_state = AST_RX_START;
						s_next.rx_cnt = 7'h00;
					end
				end
				AST_RX_START: begin
					if (s_reg.rx_cnt >= (bit_len >> 1) - 7'h01) begin
						s_next.rx_start_bad = rx_in;
						s_next.rx_cnt = 7'h00;
						s_next.rx_bits = 4'h0;
						s_next.rx_state = AST_RX_DATA;
					end else begin
						s_next.rx_cnt = s_reg.rx_cnt + 7'h01;
					end
				end
				AST_RX_DATA: begin
					if (s_reg.rx_cnt >= bit_len - 7'h01) begin
						s_next.rx_cnt = 7'h00;
						s_next.rx_shift = {rx_in, s_reg.rx_shift[8:1]};
						s_next.rx_bits = s_reg.rx_bits + 4'h1;
						if (s_reg.rx_bits + 4'h1 == rx_len) begin
							s_next.rx_state = AST_RX_STOP;
						end
					end else begin
						s_next.rx_cnt = s_reg.rx_cnt + 7'h01;
					end
				end
				AST_RX_STOP: begin
					if (s_reg.rx_cnt >= bit_len - 7'h01) begin
						s_next.rx_state = AST_RX_IDLE;
						s_next.rx_hold = rx_word;
						if (s_reg.rx_full) begin
							s_next.rx_oerr = 1'b1;
						end
						s_next.rx_full = 1'b1;
						s_next.rx_serr = s_reg.rx_start_bad;
						s_next.rx_perr = s_reg.fmt[FMT_PAR_EN_BIT] & rx_par_bit;
						s_next.rx_ferr = !rx_in;
						s_next.irq[0] = 1'b1;
					end else begin
						s_next.rx_cnt = s_reg.rx_cnt + 7'h01;
					end
				end
				default: begin
					s_next.rx_state = AST_RX_IDLE;
				end
			endcase
		end

		if (s_reg.ctrl[CTL_ECHO_BIT]) begin
			s_next.pin_tx = rx_in ^ s_reg.ctrl[CTL_TX_INV_BIT];
		end else begin
			s_next.pin_tx = s_reg.tx_line ^ s_reg.ctrl[CTL_TX_INV_BIT];
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s_reg <= '0;
			s_reg.hreadyout <= 1'b1;
			s_reg.fmt <= FMT_RESET;
			s_reg.ctrl <= CTL_RESET;
			s_reg.tx_hold <= HOLD_RESET;
			s_reg.rx_hold <= HOLD_RESET;
			s_reg.tx_line <= 1'b1;
			s_reg.pin_tx <= 1'b1;
			s_reg.rx_pin <= 1'b1;
		end else begin
			s_reg <= s_next;
		end
	end

	assign hrdata = s_reg.hrdata;
	assign hreadyout = s_reg.hreadyout;
	assign hresp = 1'b0;
	assign port_b_bit6 = s_reg.pin_tx;
	assign high_priority_irq_line = s_reg.irq;
endmodule : ast_transceiver

/* test/ast_transceiver_props.sv */
// port-level checks of the serial transceiver: bus handshake and irq pulses
// bound to ast_transceiver from the bench top; sees only its ports
`timescale 1ns/1ns
module ast_transceiver_props
	import ast_pkg::*;
(
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic port_b_bit6,
	input wire logic [1:0] high_priority_irq_line
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic take;
	assign take = hsel & hready & htrans[1] & hreadyout;
	a_take_wait: assert property (take |=> !hreadyout)
		else $error("wait state missing after address phase");
	a_take_done: assert property (take |=> ##1 hreadyout)
		else $error("transfer not done at second edge");
	a_wait_once: assert property (!hreadyout |=> hreadyout)
		else $error("wait state longer than one cycle");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_upper_zero: assert property ($rose(hreadyout) |-> hrdata[31:8] == 24'h0)
		else $error("upper read bits not zero");
	// a frame lasts far longer than eight cycles at any legal source rate
	a_tx_irq_gap: assert property (high_priority_irq_line[1] |=> !high_priority_irq_line[1] [*8])
		else $error("transmit irq not a single pulse");
	a_rx_irq_gap: assert property (high_priority_irq_line[0] |=> !high_priority_irq_line[0] [*8])
		else $error("receive irq not a single pulse");
	a_line_idle: assert property ($rose(hresetn) |-> port_b_bit6)
		else $error("transmit line not idle high after reset");
	c_write: cover property (take && hwrite);
	c_tx_irq: cover property (high_priority_irq_line[1]);
	c_rx_irq: cover property (high_priority_irq_line[0]);
endmodule : ast_transceiver_props

/* test/ast_remote.sv */
// remote serial station: sends frames to the dut and captures frames from it
// assumes callers enter just after a rising hclk edge; bit time in hclk cycles
`timescale 1ns/1ns
module ast_remote(
	input wire logic hclk,
	input wire logic from_dut,
	output logic to_dut
);
	initial to_dut = 1'b1;
	task automatic send(input logic [8:0] bits, input int n, input logic stop, input int bc);
		to_dut <= 1'b0;
		repeat (bc) @(posedge hclk);
		for (int i = 0; i < n; i++) begin
			to_dut <= bits[i];
			repeat (bc) @(posedge hclk);
		end
		to_dut <= stop;
		repeat (bc) @(posedge hclk);
		// one idle bit so the dut finishes its transfer before the caller looks
		to_dut <= 1'b1;
		repeat (bc) @(posedge hclk);
	endtask : send
	// width is the first high run after the start bit: the start bit may be short by up to one
	// sample tick, since loading is not aligned to the tick grid, so callers send a word whose
	// two lowest bits are 1 then 0
	task automatic recv(input int n, input int bc, output logic [10:0] bits, output int width);
		int ph;
		bits = '0;
		width = 0;
		ph = 0;
		while (from_dut !== 1'b0) @(posedge hclk);
		for (int c = 0; c < bc * (n + 2); c++) begin
			@(posedge hclk);
			if (ph == 1 && from_dut !== 1'b1) ph = 2;
			if (ph == 0 && from_dut === 1'b1) ph = 1;
			if (ph == 1) width++;
			if (c % bc == bc / 2) bits[c / bc] = from_dut;
		end
	endtask : recv
endmodule : ast_remote

/* test/tb_async_serial_transceiver.sv */
// bench top: registers over the bus, frames through the remote station
// assumes all three source clocks may share one hclk/2 toggle
`timescale 1ns/1ns
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin err_total++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_async_serial_transceiver
	import ast_pkg::*;
;
	logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ext_sel, rx_line, tx_line;
	logic src_clk = 1'b0;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans, irq;
	logic [2:0] hsize;
	logic [10:0] frame;
	int err_total, cmp_count, width;
	int tx_irqs = 0;
	int rx_irqs = 0;
	assign hready = hreadyout;
	ast_transceiver u_dut(.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hrdata,
		.hreadyout, .hresp, .rc_clock_in(src_clk), .external_clock_in(src_clk), .crystal_clock_in(src_clk),
		.external_clock_select(ext_sel), .port_b_bit7(rx_line), .port_b_bit6(tx_line), .high_priority_irq_line(irq));
	ast_remote u_remote(.hclk, .from_dut(tx_line), .to_dut(rx_line));
	initial begin
		hclk = 1'b0;
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		src_clk <= ~src_clk;
		tx_irqs <= tx_irqs + int'(irq[1] === 1'b1);
		rx_irqs <= rx_irqs + int'(irq[0] === 1'b1);
	end
	task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] wd, output logic [31:0] rd);
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		haddr <= {24'h0, a};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] x;
		bus(1'b1, a, d, x);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'b0, a, 8'h0, x);
		`CHK($sformatf("reg %h", a), e, x)
	endtask : rd
	task automatic results;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : results
	task automatic t_regs;
		rd(OFF_FORMAT, 8'h01);
		rd(OFF_LINE_CTRL, 8'h05);
		rd(OFF_TX_HOLD, 8'h00);
		rd(OFF_TX_STATUS, 8'h00);
		rd(OFF_RX_HOLD, 8'h00);
		rd(OFF_RX_STATUS, 8'h00);
		rd(8'h18, 8'h00);
		wr(OFF_FORMAT, 8'hff);
		rd(OFF_FORMAT, 8'hbf);
		wr(OFF_TX_STATUS, 8'hff);
		rd(OFF_TX_STATUS, 8'h00);
	endtask : t_regs
	task automatic t_echo;
		wr(OFF_LINE_CTRL, 8'h90);
		u_remote.to_dut <= 1'b0;
		repeat (4) @(posedge hclk);
		`CHK("echo low", 1'b1, tx_line)
		u_remote.to_dut <= 1'b1;
		repeat (4) @(posedge hclk);
		`CHK("echo high", 1'b0, tx_line)
	endtask : t_echo
	task automatic t_tx;
		wr(OFF_FORMAT, 8'h03);
		wr(OFF_LINE_CTRL, 8'h47);
		wr(OFF_TX_HOLD, 8'ha5);
		rd(OFF_TX_STATUS, 8'h01);
		rd(OFF_TX_HOLD, 8'ha5);
		fork
			u_remote.recv(9, 32, frame, width);
			wr(OFF_LINE_CTRL, 8'h67);
		join
		`CHK("tx frame", 11'h54a, frame)
		`CHK("rc bit time", 32, width)
		`CHK("tx irqs", 1, tx_irqs)
	endtask : t_tx
	task automatic t_rx;
		u_remote.send(9'h03c, 9, 1'b1, 32);
		rd(OFF_RX_STATUS, 8'h01);
		rd(OFF_TX_STATUS, 8'h00);
		rd(OFF_RX_HOLD, 8'h3c);
		rd(OFF_RX_STATUS, 8'h00);
		u_remote.send(9'h13c, 9, 1'b1, 32);
		rd(OFF_RX_STATUS, 8'h11);
		u_remote.send(9'h03c, 9, 1'b1, 32);
		rd(OFF_RX_STATUS, 8'h05);
		wr(OFF_RX_STATUS, 8'h00);
		rd(OFF_RX_STATUS, 8'h01);
		rd(OFF_RX_HOLD, 8'h3c);
		wr(OFF_FORMAT, 8'h06);
		u_remote.send(9'h0bc, 8, 1'b1, 32);
		rd(OFF_RX_STATUS, 8'h01);
		rd(OFF_RX_HOLD, 8'h3c);
		`CHK("rx irqs", 4, rx_irqs)
	endtask : t_rx
	task automatic t_rate(input logic [7:0] fmt, input logic [7:0] ctl, input int bc);
		wr(OFF_FORMAT, fmt);
		wr(OFF_LINE_CTRL, ctl);
		fork
			u_remote.recv(8, bc, frame, width);
			wr(OFF_TX_HOLD, 8'h55);
		join
		`CHK("rate frame", 11'h2aa, frame)
		`CHK("rate bit time", bc, width)
	endtask : t_rate
	initial begin
		hresetn = 1'b0;
		hsel = 1'b1;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'h0;
		hsize = 3'h2;
		ext_sel = 1'b0;
		err_total = 0;
		cmp_count = 0;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_regs();
		t_echo();
		t_tx();
		t_rx();
		ext_sel <= 1'b1;
		t_rate(8'h01, 8'h67, 64);
		t_rate(8'h81, 8'h63, 28);
		t_rate(8'h81, 8'h62, 56);
		results();
	end
	// eight frames of a few hundred cycles each fit well inside this
	initial begin
		repeat (40000) @(posedge hclk);
		err_total++;
		results();
	end
endmodule : tb_async_serial_transceiver
bind ast_transceiver ast_transceiver_props u_props(.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready, .hrdata,
	.hreadyout, .hresp, .port_b_bit6, .high_priority_irq_line);
